// ### stsm_pkg.sv
// Shared constants and types for the standstill monitor
package stsm_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int POS_W = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_POS_WIN = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_VEL_WIN = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DELAY = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CENTRE = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_VELOCITY = 8'h20;

   // Control fields
   localparam int CTRL_W = 7;
   localparam int CTRL_FUNC_EN = 0;
   localparam int CTRL_ACT_SAFE_IN = 1;
   localparam int CTRL_ACT_FSOE = 2;
   localparam int CTRL_VEL_MON = 3;
   localparam int CTRL_MANUAL = 4;
   localparam int CTRL_ACK_SAFE_IN = 5;
   localparam int CTRL_ACK_FSOE = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

   // Status fields
   localparam int STAT_W = 4;
   localparam int STAT_ACTIVE = 0;
   localparam int STAT_MONITOR = 1;
   localparam int STAT_FAULT = 2;
   localparam int STAT_RESTART = 3;

   // Interrupt events
   localparam int IRQ_W = 4;
   localparam int IRQ_ACTIVATED = 0;
   localparam int IRQ_POS_VIOL = 1;
   localparam int IRQ_VEL_VIOL = 2;
   localparam int IRQ_RESTART = 3;
   localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

   localparam logic [POS_W-1:0] POS_WIN_RST = 32'h0000_0001;
   localparam logic [POS_W-1:0] VEL_WIN_RST = 32'h0000_0000;

   // Monitoring delay, register counts microseconds
   localparam int DELAY_W = 16;
   localparam logic [DELAY_W-1:0] DELAY_RST_US = 16'h03e8;
   localparam int CLK_PERIOD_NS = 20;
   localparam int US_NS = 1000;
   localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int US_CNT_W = 6;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_DELAY = 5'h02,
      ST_MON = 5'h04,
      ST_FAULT = 5'h08,
      ST_WAIT = 5'h10
   } stsm_state_t;
endpackage

// ### stsm_sync.sv
// Three-stage synchroniser for one safe input pin
`timescale 1ns/10ps
module stsm_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Change taken only once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level <= 1'b0;
      end else if (s2_reg == s3_reg) begin
         level <= s3_reg;
      end
   end
endmodule

// ### stsm_vel.sv
// Safe velocity derived from successive safe positions
`timescale 1ns/10ps
module stsm_vel (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic [stsm_pkg::POS_W-1:0] position,
   output logic [stsm_pkg::POS_W-1:0] velocity
);
   import stsm_pkg::*;

   logic [POS_W-1:0] prev_reg;
   logic primed_reg;

   // Position units per microsecond; first sample only primes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= '0;
         primed_reg <= 1'b0;
         velocity <= '0;
      end else if (tick) begin
         prev_reg <= position;
         primed_reg <= 1'b1;
         if (primed_reg) begin
            velocity <= position - prev_reg;
         end
      end
   end
endmodule

// ### stsm_top.sv
// Per-axis standstill monitor with APB register access
// Function
// - On start of monitoring the current safe position is kept as window centre.
// - One position window value sets both bounds around the centre.
// - A position outside the window while monitoring raises fault activate.
// - With velocity monitoring enabled the velocity is checked against its window.
// - After activation checking waits for the monitoring delay, 1 ms by default.
// - Activation is the OR of safe input, safety network and controlled stop.
// - Activation by the controlled stop skips the delay.
// - One monitor per axis with its own parameters and status.
// - Position and the derived velocity both come from safe feedback.
// - Outputs are active status, fault activate and restart request.
// - Automatic restart leaves the active state without acknowledge unless a fault was raised; leaving fault always needs one.
// - Manual restart stays active until a safe restart acknowledge.
`timescale 1ns/10ps
module stsm_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [stsm_pkg::ADDR_W-1:0] paddr,
   input wire logic [stsm_pkg::DATA_W-1:0] pwdata,
   output logic [stsm_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [stsm_pkg::POS_W-1:0] safe_position,
   input wire logic fsoe_activate,
   input wire logic fsoe_restart_ack,
   input wire logic controlled_stop_request,
   input wire logic safe_in_activate,
   input wire logic safe_in_restart_ack,
   output logic standstill_active,
   output logic fault_activate,
   output logic restart_request,
   output logic irq
);
   import stsm_pkg::*;

   logic [CTRL_W-1:0] ctrl_reg;
   logic [POS_W-1:0] pos_win_reg;
   logic [POS_W-1:0] vel_win_reg;
   logic [DELAY_W-1:0] delay_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [POS_W-1:0] centre_reg;
   logic [DELAY_W-1:0] dly_cnt_reg;
   logic [US_CNT_W-1:0] us_cnt_reg;
   logic us_tick;
   stsm_state_t state_reg;
   stsm_state_t state_next;
   logic si_act;
   logic si_ack;
   logic [POS_W-1:0] velocity;
   logic act_req;
   logic ack;
   logic manual;
   logic pos_viol;
   logic vel_viol;
   logic signed [POS_W:0] pos_diff;
   logic [POS_W:0] pos_abs;
   logic [POS_W:0] vel_abs;
   logic wr_en;
   logic dec_ok;
   logic [DATA_W-1:0] rd_mux;
   logic [IRQ_W-1:0] irq_event;

   // Safe input pins come from outside the clock domain
   stsm_sync u_sync_act (.pclk(pclk), .presetn(presetn),
      .pin(safe_in_activate), .level(si_act));
   stsm_sync u_sync_ack (.pclk(pclk), .presetn(presetn),
      .pin(safe_in_restart_ack), .level(si_ack));

   // Microsecond enable for delay and velocity sampling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         us_cnt_reg <= '0;
         us_tick <= 1'b0;
      end else if (us_cnt_reg == US_CNT_W'(CYC_PER_US - 1)) begin
         us_cnt_reg <= '0;
         us_tick <= 1'b1;
      end else begin
         us_cnt_reg <= us_cnt_reg + 1'b1;
         us_tick <= 1'b0;
      end
   end

   stsm_vel u_vel (.pclk(pclk), .presetn(presetn), .tick(us_tick),
      .position(safe_position), .velocity(velocity));

   // Mapped inputs only count when enabled
   assign act_req = ctrl_reg[CTRL_FUNC_EN] &
      ((ctrl_reg[CTRL_ACT_SAFE_IN] & si_act) |
       (ctrl_reg[CTRL_ACT_FSOE] & fsoe_activate) |
       controlled_stop_request);
   assign ack = (ctrl_reg[CTRL_ACK_SAFE_IN] & si_ack) |
      (ctrl_reg[CTRL_ACK_FSOE] & fsoe_restart_ack);
   assign manual = ctrl_reg[CTRL_MANUAL];

   // Widened by one bit so the difference never wraps
   assign pos_diff = $signed({safe_position[POS_W-1], safe_position}) -
      $signed({centre_reg[POS_W-1], centre_reg});
   assign pos_abs = pos_diff[POS_W] ? (POS_W+1)'(-pos_diff) : pos_diff;
   assign pos_viol = pos_abs > {1'b0, pos_win_reg};
   assign vel_abs = velocity[POS_W-1] ?
      (POS_W+1)'(-$signed({1'b1, velocity})) : {1'b0, velocity};
   assign vel_viol = ctrl_reg[CTRL_VEL_MON] &
      (vel_abs > {1'b0, vel_win_reg});

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (act_req && controlled_stop_request) begin
               state_next = ST_MON;
            end else if (act_req) begin
               state_next = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (!act_req) begin
               state_next = manual ? ST_WAIT : ST_IDLE;
            end else if (dly_cnt_reg == '0) begin
               state_next = ST_MON;
            end
         end
         ST_MON: begin
            if (pos_viol || vel_viol) begin
               state_next = ST_FAULT;
            end else if (!act_req) begin
               state_next = manual ? ST_WAIT : ST_IDLE;
            end
         end
         ST_FAULT: begin
            if (!act_req && ack) begin
               state_next = ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (ack) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_FAULT;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Delay counts microseconds from activation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_cnt_reg <= '0;
      end else if (state_reg == ST_IDLE) begin
         dly_cnt_reg <= delay_reg;
      end else if (state_reg == ST_DELAY && us_tick &&
                   dly_cnt_reg != '0) begin
         dly_cnt_reg <= dly_cnt_reg - 1'b1;
      end
   end

   // Centre frozen from monitoring start to the end of the activation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         centre_reg <= '0;
      end else if (state_next == ST_MON && state_reg != ST_MON) begin
         centre_reg <= safe_position;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standstill_active <= 1'b0;
         fault_activate <= 1'b0;
         restart_request <= 1'b0;
      end else begin
         standstill_active <= state_next != ST_IDLE;
         fault_activate <= state_next == ST_FAULT;
         restart_request <= state_next == ST_WAIT;
      end
   end

   // Interrupt events; set wins over a write-one clear
   assign irq_event[IRQ_ACTIVATED] = state_reg == ST_IDLE &&
      state_next != ST_IDLE;
   assign irq_event[IRQ_POS_VIOL] = state_reg == ST_MON && pos_viol;
   assign irq_event[IRQ_VEL_VIOL] = state_reg == ST_MON && vel_viol;
   assign irq_event[IRQ_RESTART] = state_reg != ST_WAIT &&
      state_next == ST_WAIT;

   // APB: one wait state, write lands on the pready edge
   always_comb begin
      dec_ok = 1'b1;
      rd_mux = '0;
      unique case (paddr)
         OFS_CTRL: rd_mux = DATA_W'(ctrl_reg);
         OFS_POS_WIN: rd_mux = pos_win_reg;
         OFS_VEL_WIN: rd_mux = vel_win_reg;
         OFS_DELAY: rd_mux = DATA_W'(delay_reg);
         OFS_STATUS: rd_mux = DATA_W'({restart_request, fault_activate,
            state_reg == ST_MON, standstill_active});
         OFS_IRQ_STAT: rd_mux = DATA_W'(irq_stat_reg);
         OFS_IRQ_MASK: rd_mux = DATA_W'(irq_mask_reg);
         OFS_CENTRE: rd_mux = centre_reg;
         OFS_VELOCITY: rd_mux = velocity;
         default: dec_ok = 1'b0;
      endcase
   end

   assign wr_en = psel & penable & pready & pwrite & dec_ok;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel & penable & ~pready;
         if (psel && penable && !pready) begin
            pslverr <= ~dec_ok;
            prdata <= pwrite ? '0 : rd_mux;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RST;
         pos_win_reg <= POS_WIN_RST;
         vel_win_reg <= VEL_WIN_RST;
         delay_reg <= DELAY_RST_US;
         irq_mask_reg <= IRQ_RST;
      end else if (wr_en) begin
         unique case (paddr)
            OFS_CTRL: ctrl_reg <= pwdata[CTRL_W-1:0];
            OFS_POS_WIN: pos_win_reg <= pwdata;
            OFS_VEL_WIN: vel_win_reg <= pwdata;
            OFS_DELAY: delay_reg <= pwdata[DELAY_W-1:0];
            OFS_IRQ_MASK: irq_mask_reg <= pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= IRQ_RST;
      end else if (wr_en && paddr == OFS_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_event;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_event;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_centre;
      $rose(state_reg == ST_MON) |-> centre_reg == $past(safe_position);
   endproperty
   a_centre: assert property (p_centre)
      else $error("centre not captured at monitoring start");
   property p_in_window;
      state_reg == ST_MON && !vel_viol && act_req &&
      pos_abs <= {1'b0, pos_win_reg} |=> !fault_activate;
   endproperty
   a_in_window: assert property (p_in_window)
      else $error("fault raised inside position window");
   property p_pos_fault;
      state_reg == ST_MON && pos_viol |=> fault_activate [*2];
   endproperty
   a_pos_fault: assert property (p_pos_fault)
      else $error("position violation without held fault");
   property p_vel_off;
      state_reg == ST_MON && !ctrl_reg[CTRL_VEL_MON] && !pos_viol &&
      act_req |=> !fault_activate;
   endproperty
   a_vel_off: assert property (p_vel_off)
      else $error("fault with velocity monitoring disabled");
   property p_vel_fault;
      state_reg == ST_MON && ctrl_reg[CTRL_VEL_MON] &&
      vel_abs > {1'b0, vel_win_reg} |=> fault_activate;
   endproperty
   a_vel_fault: assert property (p_vel_fault)
      else $error("velocity violation without fault");
   property p_delay;
      state_reg == ST_DELAY && dly_cnt_reg != '0 |=>
      state_reg != ST_MON && !fault_activate;
   endproperty
   a_delay: assert property (p_delay)
      else $error("checking started before delay expired");
   property p_fsoe_act;
      state_reg == ST_IDLE && ctrl_reg[CTRL_FUNC_EN] &&
      ctrl_reg[CTRL_ACT_FSOE] && fsoe_activate |=> standstill_active;
   endproperty
   a_fsoe_act: assert property (p_fsoe_act)
      else $error("network activation ignored");
   property p_ss2_direct;
      state_reg == ST_IDLE && ctrl_reg[CTRL_FUNC_EN] &&
      controlled_stop_request |=> state_reg == ST_MON;
   endproperty
   a_ss2_direct: assert property (p_ss2_direct)
      else $error("controlled stop did not skip the delay");
   property p_auto;
      state_reg == ST_MON && !pos_viol && !vel_viol && !act_req &&
      !manual |=> !standstill_active && !restart_request;
   endproperty
   a_auto: assert property (p_auto)
      else $error("automatic restart did not deactivate");
   property p_manual_hold;
      state_reg == ST_WAIT && !ack |=> standstill_active && restart_request;
   endproperty
   a_manual_hold: assert property (p_manual_hold)
      else $error("manual restart left without acknowledge");
   property p_req_manual;
      restart_request |-> $past(manual);
   endproperty
   a_req_manual: assert property (p_req_manual)
      else $error("restart request in automatic mode");
endmodule

// ### stsm_safety_ctrl.sv
// Safety controller model driving activation, acknowledge and position
`timescale 1ns/10ps
module stsm_safety_ctrl (
   input wire logic pclk,
   output logic [31:0] safe_position,
   output logic fsoe_activate,
   output logic fsoe_restart_ack,
   output logic controlled_stop_request,
   output logic safe_in_activate,
   output logic safe_in_restart_ack
);
   initial begin
      safe_position = 32'h0000_0064;
      fsoe_activate = 1'b0;
      fsoe_restart_ack = 1'b0;
      controlled_stop_request = 1'b0;
      safe_in_activate = 1'b0;
      safe_in_restart_ack = 1'b0;
   end

   // Source 0 network, 1 safe input, 2 controlled stop
   task act(input int src, input logic v);
      @(posedge pclk);
      case (src)
         0: fsoe_activate <= v;
         1: safe_in_activate <= v;
         default: controlled_stop_request <= v;
      endcase
   endtask

   // Held long enough to pass the pin synchroniser
   task ack(input int src);
      @(posedge pclk);
      if (src == 0) fsoe_restart_ack <= 1'b1;
      else safe_in_restart_ack <= 1'b1;
      repeat (6) @(posedge pclk);
      fsoe_restart_ack <= 1'b0;
      safe_in_restart_ack <= 1'b0;
   endtask

   task move(input logic [31:0] p);
      @(posedge pclk);
      safe_position <= p;
   endtask
endmodule

// ### test_safe_operating_stop_monitor.sv
// Self-checking bench for the standstill monitor
`timescale 1ns/10ps
module test_safe_operating_stop_monitor;
   import stsm_pkg::*;
   logic pclk = 1'b0;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic pready, pslverr, irq;
   logic [POS_W-1:0] safe_position;
   logic fsoe_activate, fsoe_restart_ack, controlled_stop_request;
   logic safe_in_activate, safe_in_restart_ack;
   logic standstill_active, fault_activate, restart_request;
   logic [31:0] rd;
   logic er;
   int err_total = 0;
   int samples_checked = 0;

   always #10 pclk = ~pclk;

   stsm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .safe_position(safe_position), .fsoe_activate(fsoe_activate),
      .fsoe_restart_ack(fsoe_restart_ack),
      .controlled_stop_request(controlled_stop_request),
      .safe_in_activate(safe_in_activate),
      .safe_in_restart_ack(safe_in_restart_ack),
      .standstill_active(standstill_active),
      .fault_activate(fault_activate), .restart_request(restart_request),
      .irq(irq));

   stsm_safety_ctrl i_ctrl (.pclk(pclk), .safe_position(safe_position),
      .fsoe_activate(fsoe_activate), .fsoe_restart_ack(fsoe_restart_ack),
      .controlled_stop_request(controlled_stop_request),
      .safe_in_activate(safe_in_activate),
      .safe_in_restart_ack(safe_in_restart_ack));

   task results;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_total++;
         $display("[ERR] pready expected 1 seen %b", pready);
         results;
      end
   endtask

   function logic sig(input int s);
      case (s)
         0: return standstill_active;
         1: return fault_activate;
         2: return restart_request;
         default: return irq;
      endcase
   endfunction

   task wt(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (sig(s) !== v && n < lim) begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (n >= lim) begin
         err_total++;
         $display("[ERR] wait on output %0d expected %b seen %b", s, v,
            sig(s));
         results;
      end
   endtask

   task t_reset_regs;
      apb(0, OFS_CTRL, 0);
      chk("ctrl", 32'h0, rd);
      apb(0, OFS_POS_WIN, 0);
      chk("pos_win", 32'h1, rd);
      apb(0, OFS_VEL_WIN, 0);
      chk("vel_win", 32'h0, rd);
      apb(0, OFS_DELAY, 0);
      chk("delay", 32'h3e8, rd);
      apb(0, 8'h40, 0);
      chk("unmapped err", 32'h1, {31'h0, er});
   endtask

   // Controlled stop, no delay, window around captured centre
   task t_position_fault;
      apb(1, OFS_POS_WIN, 32'h5);
      apb(1, OFS_CTRL, 32'h41);
      i_ctrl.act(2, 1'b1);
      @(posedge pclk);
      #1;
      chk("active", 32'h1, {31'h0, standstill_active});
      apb(0, OFS_STATUS, 0);
      chk("monitoring", 32'h1, {31'h0, rd[STAT_MONITOR]});
      apb(0, OFS_CENTRE, 0);
      chk("centre", 32'h64, rd);
      chk("irq masked", 32'h0, {31'h0, irq});
      i_ctrl.move(32'h69);
      repeat (10) @(posedge pclk);
      #1;
      chk("edge of window", 32'h0, {31'h0, fault_activate});
      i_ctrl.move(32'h6a);
      wt(1, 1'b1, 4);
      apb(1, OFS_IRQ_MASK, 32'h2);
      wt(3, 1'b1, 3);
      i_ctrl.act(2, 1'b0);
      repeat (5) @(posedge pclk);
      #1;
      chk("fault holds", 32'h1, {31'h0, fault_activate});
      i_ctrl.ack(0);
      wt(0, 1'b0, 5);
      apb(0, OFS_IRQ_STAT, 0);
      chk("irq events", 32'h3, rd);
      apb(1, OFS_IRQ_STAT, 32'hf);
      apb(0, OFS_IRQ_STAT, 0);
      chk("irq_stat", 32'h0, rd);
      chk("irq low", 32'h0, {31'h0, irq});
   endtask

   // Network activation waits for the delay, auto restart
   task t_delay_auto;
      int n;
      apb(1, OFS_DELAY, 32'h2);
      apb(1, OFS_CTRL, 32'h05);
      i_ctrl.act(0, 1'b1);
      wt(0, 1'b1, 3);
      apb(0, OFS_STATUS, 0);
      chk("in delay", 32'h0, {31'h0, rd[STAT_MONITOR]});
      n = 0;
      do begin
         apb(0, OFS_STATUS, 0);
         n++;
      end while (rd[STAT_MONITOR] !== 1'b1 && n < 80);
      chk("monitoring late", 32'h1, {31'h0, n > 10});
      chk("monitoring", 32'h1, {31'h0, rd[STAT_MONITOR]});
      i_ctrl.act(0, 1'b0);
      wt(0, 1'b0, 3);
   endtask

   // Safe input needs mapping, manual restart needs acknowledge
   task t_manual;
      apb(1, OFS_CTRL, 32'h31);
      i_ctrl.act(1, 1'b1);
      repeat (10) @(posedge pclk);
      #1;
      chk("unmapped input", 32'h0, {31'h0, standstill_active});
      apb(1, OFS_CTRL, 32'h33);
      wt(0, 1'b1, 8);
      i_ctrl.act(1, 1'b0);
      wt(2, 1'b1, 8);
      apb(0, OFS_IRQ_STAT, 0);
      chk("restart event", 32'h9, rd);
      i_ctrl.ack(0);
      chk("still active", 32'h1, {31'h0, standstill_active});
      i_ctrl.ack(1);
      wt(0, 1'b0, 6);
      chk("request off", 32'h0, {31'h0, restart_request});
   endtask

   // Velocity from position steps checked against a zero window
   task t_velocity;
      apb(0, OFS_VELOCITY, 0);
      chk("velocity at rest", 32'h0, rd);
      apb(1, OFS_POS_WIN, 32'h3e8);
      apb(1, OFS_CTRL, 32'h49);
      i_ctrl.act(2, 1'b1);
      repeat (120) @(posedge pclk);
      #1;
      chk("still axis", 32'h0, {31'h0, fault_activate});
      i_ctrl.move(32'h6d);
      wt(1, 1'b1, 120);
      i_ctrl.act(2, 1'b0);
      i_ctrl.ack(0);
      wt(0, 1'b0, 6);
   endtask

   initial begin
      presetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= '0;
      pwdata <= '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_regs;
      t_position_fault;
      t_delay_auto;
      t_manual;
      t_velocity;
      results;
   end
endmodule
